// ### include/bbr_defines.svh
// constants of the baseband tuning and signal-strength register bank
// assumes byte-wide registers on a plain address/strobe port
`ifndef BBR_DEFINES_SVH
`define BBR_DEFINES_SVH

`define BBR_ADDR_W            8
`define BBR_OFS_CTRL_TWO      8'h3A
`define BBR_OFS_PRE_THR       8'h3B
`define BBR_OFS_CS_PREAMBLE_COUNTER_THRESHOLD     8'h3C
`define BBR_OFS_STRENGTH      8'h3E

`define BBR_RST_CTRL_TWO      8'h00
`define BBR_RST_PRE_THR       8'hD8
`define BBR_RST_CS_PREAMBLE_COUNTER_THRESHOLD     8'h9C
`define BBR_RST_STRENGTH      8'h01

`define BBR_PRE_VALID_HI      7
`define BBR_PRE_VALID_LO      4
`define BBR_PRE_ENERGY_HI     3
`define BBR_PRE_ENERGY_LO     1
`define BBR_CS_HI             7
`define BBR_CS_LO             5
`define BBR_PREAMBLE_COUNTER_THRESHOLD_HI         4
`define BBR_PREAMBLE_COUNTER_THRESHOLD_LO         2
`define BBR_ONESHOT_BIT       7
`define BBR_PER_PACKET_BIT    6
`define BBR_READY_BIT         0

`define BBR_CTRL_TWO_MASK     8'hFC
`define BBR_PRE_THR_MASK      8'hFE
`define BBR_CS_PREAMBLE_COUNTER_THRESHOLD_MASK    8'hFC

`define BBR_MEAS_CYCLES       16

`endif

// ### include/bbr_pkg.sv
// types of the baseband tuning and signal-strength register bank
// assumes bbr_defines.svh is on the include path
`include "bbr_defines.svh"
package bbr_pkg;
    typedef logic [7:0] bbr_byte_t;
    typedef logic [`BBR_ADDR_W-1:0] bbr_addr_t;
    typedef enum logic [0:0] {
        BBR_MEAS_IDLE,
        BBR_MEAS_BUSY
    } bbr_meas_state_t;
endpackage

// ### include/bbr_meas_if.sv
// link between the register bank and the one-shot measurement sequencer
// assumes both ends share one clock
`timescale 1ns/10ps
interface bbr_meas_if;
    logic start;
    logic done;
    modport bank (output start, input done);
    modport seq  (input start, output done);
endinterface

// ### rtl/bbr_meas_seq.sv
// one-shot signal-strength measurement sequencer
// assumes start is a one-cycle pulse on the bank's clock
`timescale 1ns/10ps
`include "bbr_defines.svh"
module bbr_meas_seq #(
    parameter int MEAS_CYCLES = `BBR_MEAS_CYCLES
) (
    input  wire logic  clock,
    input  wire logic  rst,
    bbr_meas_if.seq    meas,
    output logic       latch_value
);
    import bbr_pkg::*;

    localparam int CW = $clog2(MEAS_CYCLES + 1);

    bbr_meas_state_t state_r, state_nxt;
    logic [CW-1:0]   cnt_r, cnt_nxt;
    logic            done_r, done_nxt;

    assign meas.done   = done_r;
    assign latch_value = done_r;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        done_nxt  = 1'b0;
        unique case (state_r)
            BBR_MEAS_IDLE: begin
                if (meas.start) begin
                    state_nxt = BBR_MEAS_BUSY;
                    cnt_nxt   = CW'(MEAS_CYCLES - 1);
                end
            end
            BBR_MEAS_BUSY: begin
                // a retrigger restarts the measurement window
                if (meas.start) begin
                    cnt_nxt = CW'(MEAS_CYCLES - 1);
                end else if (cnt_r == '0) begin
                    state_nxt = BBR_MEAS_IDLE;
                    done_nxt  = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - CW'(1);
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= BBR_MEAS_IDLE;
            cnt_r   <= '0;
            done_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            done_r  <= done_nxt;
        end
    end
endmodule

// ### rtl/bbr_regs.sv
// baseband tuning and signal-strength control register bank
// assumes a one-clock host port with one-cycle strobes, read data one cycle later
`timescale 1ns/10ps
`include "bbr_defines.svh"
module bbr_regs #(
    parameter int MEAS_CYCLES = `BBR_MEAS_CYCLES
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire bbr_pkg::bbr_addr_t addr,
    input  wire bbr_pkg::bbr_byte_t wdata,
    input  wire logic             wr,
    input  wire logic             rd,
    output bbr_pkg::bbr_byte_t    rdata,
    output logic [3:0]            preamble_valid_threshold,
    output logic [2:0]            preamble_search_energy_threshold,
    output logic [2:0]            carrier_sense_threshold,
    output logic [2:0]            preamble_counter_threshold,
    output logic                  strength_per_packet_enable,
    output logic                  strength_measure_start,
    output logic                  strength_latch
);
    import bbr_pkg::*;

    localparam bbr_byte_t RST_STRENGTH = `BBR_RST_STRENGTH;

    bbr_byte_t ctrl_two_r,   ctrl_two_nxt;
    bbr_byte_t pre_thr_r,    pre_thr_nxt;
    bbr_byte_t cs_preamble_counter_threshold_r,  cs_preamble_counter_threshold_nxt;
    logic      per_pkt_r,    per_pkt_nxt;
    logic      ready_r,      ready_nxt;
    logic      start_r,      start_nxt;
    logic      latch_r,      latch_nxt;
    bbr_byte_t rdata_r,      rdata_nxt;
    logic      seq_latch;

    bbr_meas_if meas ();

    assign meas.start = start_r;

    bbr_meas_seq #(
        .MEAS_CYCLES (MEAS_CYCLES)
    ) u_seq (
        .clock       (clock),
        .rst         (rst),
        .meas        (meas),
        .latch_value (seq_latch)
    );

    function automatic bbr_byte_t read_mux(input bbr_addr_t a, input bbr_byte_t c2, input bbr_byte_t pt,
                                           input bbr_byte_t cp, input logic pp, input logic rdy);
        bbr_byte_t v;
        v = 8'h00;
        unique case (a)
            `BBR_OFS_CTRL_TWO:  v = c2;
            `BBR_OFS_PRE_THR:   v = pt;
            `BBR_OFS_CS_PREAMBLE_COUNTER_THRESHOLD: v = cp;
            // trigger bit is write-only and always reads zero
            `BBR_OFS_STRENGTH: begin
                v[`BBR_PER_PACKET_BIT] = pp;
                v[`BBR_READY_BIT]      = rdy;
            end
            default:            v = 8'h00;
        endcase
        return v;
    endfunction

    always_comb begin
        ctrl_two_nxt  = ctrl_two_r;
        pre_thr_nxt   = pre_thr_r;
        cs_preamble_counter_threshold_nxt = cs_preamble_counter_threshold_r;
        per_pkt_nxt   = per_pkt_r;
        ready_nxt     = ready_r;
        start_nxt     = 1'b0;
        latch_nxt     = meas.done;
        rdata_nxt     = 8'h00;
        // reserved bits are held at zero whatever the host writes
        if (wr) begin
            unique case (addr)
                `BBR_OFS_CTRL_TWO:  ctrl_two_nxt  = wdata & `BBR_CTRL_TWO_MASK;
                `BBR_OFS_PRE_THR:   pre_thr_nxt   = wdata & `BBR_PRE_THR_MASK;
                `BBR_OFS_CS_PREAMBLE_COUNTER_THRESHOLD: cs_preamble_counter_threshold_nxt = wdata & `BBR_CS_PREAMBLE_COUNTER_THRESHOLD_MASK;
                `BBR_OFS_STRENGTH: begin
                    per_pkt_nxt = wdata[`BBR_PER_PACKET_BIT];
                    start_nxt   = wdata[`BBR_ONESHOT_BIT];
                end
                default: ;
            endcase
        end
        // completion raises ready, only from the one-shot sequencer
        if (meas.done) begin
            ready_nxt = 1'b1;
        end
        // a new trigger wins over a completion in the same cycle
        if (start_r) begin
            ready_nxt = 1'b0;
        end
        if (rd) begin
            rdata_nxt = read_mux(addr, ctrl_two_r, pre_thr_r, cs_preamble_counter_threshold_r, per_pkt_r, ready_r);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_two_r  <= `BBR_RST_CTRL_TWO;
            pre_thr_r   <= `BBR_RST_PRE_THR;
            cs_preamble_counter_threshold_r <= `BBR_RST_CS_PREAMBLE_COUNTER_THRESHOLD;
            per_pkt_r   <= RST_STRENGTH[`BBR_PER_PACKET_BIT];
            ready_r     <= RST_STRENGTH[`BBR_READY_BIT];
            start_r     <= 1'b0;
            latch_r     <= 1'b0;
            rdata_r     <= 8'h00;
        end else begin
            ctrl_two_r  <= ctrl_two_nxt;
            pre_thr_r   <= pre_thr_nxt;
            cs_preamble_counter_threshold_r <= cs_preamble_counter_threshold_nxt;
            per_pkt_r   <= per_pkt_nxt;
            ready_r     <= ready_nxt;
            start_r     <= start_nxt;
            latch_r     <= latch_nxt;
            rdata_r     <= rdata_nxt;
        end
    end

    assign rdata                            = rdata_r;
    assign preamble_valid_threshold         = pre_thr_r[`BBR_PRE_VALID_HI:`BBR_PRE_VALID_LO];
    assign preamble_search_energy_threshold = pre_thr_r[`BBR_PRE_ENERGY_HI:`BBR_PRE_ENERGY_LO];
    assign carrier_sense_threshold          = cs_preamble_counter_threshold_r[`BBR_CS_HI:`BBR_CS_LO];
    assign preamble_counter_threshold       = cs_preamble_counter_threshold_r[`BBR_PREAMBLE_COUNTER_THRESHOLD_HI:`BBR_PREAMBLE_COUNTER_THRESHOLD_LO];
    assign strength_per_packet_enable       = per_pkt_r;
    assign strength_measure_start           = start_r;
    assign strength_latch                   = latch_r;
endmodule

// ### sim/bbr_regs_monitor.sv
// port checker of the baseband bank
// bound into bbr_regs
`timescale 1ns/10ps
module bbr_regs_monitor #(parameter int MEAS_CYCLES = 16) (
    input wire logic               clock,
    input wire logic               rst,
    input wire bbr_pkg::bbr_addr_t addr,
    input wire bbr_pkg::bbr_byte_t wdata,
    input wire logic               wr,
    input wire logic               rd,
    input wire bbr_pkg::bbr_byte_t rdata,
    input wire logic [3:0]         preamble_valid_threshold,
    input wire logic               strength_per_packet_enable,
    input wire logic               strength_measure_start,
    input wire logic               strength_latch
);
    import bbr_pkg::*;
    localparam int LAT = MEAS_CYCLES + 2;
    logic busy_r;
    wire logic w3e = wr && addr == 8'h3E;
    wire logic r3e = rd && addr == 8'h3E;
    wire logic rdy = !busy_r || strength_latch;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    always_ff @(posedge clock) begin
        busy_r <= !rst && (strength_measure_start || busy_r && !strength_latch);
    end
    property p_rst; $fell(rst) |-> preamble_valid_threshold == 4'hD; endproperty
    a_rst: assert property (p_rst) else $error("reset");
    property p_go; w3e && wdata[7] |=> strength_measure_start; endproperty
    a_go: assert property (p_go) else $error("start");
    property p_clr; r3e |=> !rdata[7]; endproperty
    a_clr: assert property (p_clr) else $error("trigger");
    property p_pp; w3e |=> strength_per_packet_enable == $past(wdata[6]); endproperty
    a_pp: assert property (p_pp) else $error("packet");
    property p_lat; strength_measure_start |-> ##LAT strength_latch; endproperty
    a_lat: assert property (p_lat) else $error("latch");
    property p_busy; r3e && !rdy |=> !rdata[0]; endproperty
    a_busy: assert property (p_busy) else $error("busy");
    property p_done; r3e && rdy |=> rdata[0]; endproperty
    a_done: assert property (p_done) else $error("ready");
    property p_pk; w3e && !wdata[7] |=> !strength_measure_start; endproperty
    a_pk: assert property (p_pk) else $error("spurious");
    c_lat: cover property (strength_latch);
    c_busy: cover property (r3e && !rdy);
    c_pp: cover property (w3e && wdata[6]);
endmodule

// ### sim/bbr_host.sv
// host model on the bank's register port
// one-cycle strobes, read data one cycle later
`timescale 1ns/10ps
module bbr_host (
    input  wire logic               clock,
    output bbr_pkg::bbr_addr_t      addr,
    output bbr_pkg::bbr_byte_t      wdata,
    output logic                    wr,
    output logic                    rd,
    input  wire bbr_pkg::bbr_byte_t rdata
);
    import bbr_pkg::*;
    initial {addr, wdata, wr, rd} = 18'h0;
    task automatic xfer(input logic w, input bbr_addr_t a, input bbr_byte_t d, output bbr_byte_t q);
        @(posedge clock);
        addr <= a;
        wdata <= d & (a == 8'h3E ? 8'hC0 : a == 8'h3B ? 8'hFE : 8'hFC);
        wr <= w;
        rd <= !w;
        @(posedge clock);
        {wr, rd} <= 2'h0;
        #1 q = rdata;
    endtask
endmodule

// ### sim/bbr_regs_tb.sv
// self-checking bench of the baseband bank
// host model drives the register port
`timescale 1ns/10ps
module bbr_regs_tb;
    import bbr_pkg::*;
    logic       clock = 1'h0;
    logic       rst = 1'h1;
    logic       wr, rd, strength_per_packet_enable, strength_measure_start, strength_latch;
    bbr_addr_t  addr;
    bbr_byte_t  wdata, rdata, q;
    logic [3:0] preamble_valid_threshold;
    logic [2:0] preamble_search_energy_threshold, carrier_sense_threshold, preamble_counter_threshold;
    int         num_errors = 0, cmp_count = 0;
    bbr_regs #(
        .MEAS_CYCLES (2)
    ) dut (
        .clock                            (clock),
        .rst                              (rst),
        .addr                             (addr),
        .wdata                            (wdata),
        .wr                               (wr),
        .rd                               (rd),
        .rdata                            (rdata),
        .preamble_valid_threshold         (preamble_valid_threshold),
        .preamble_search_energy_threshold (preamble_search_energy_threshold),
        .carrier_sense_threshold          (carrier_sense_threshold),
        .preamble_counter_threshold       (preamble_counter_threshold),
        .strength_per_packet_enable       (strength_per_packet_enable),
        .strength_measure_start           (strength_measure_start),
        .strength_latch                   (strength_latch)
    );
    bbr_host host (
        .clock (clock),
        .addr  (addr),
        .wdata (wdata),
        .wr    (wr),
        .rd    (rd),
        .rdata (rdata)
    );
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rchk(input string what, input bbr_addr_t a, input bbr_byte_t e);
        host.xfer(1'h0, a, 8'h00, q);
        check(what, q, e);
    endtask
    // threshold outputs are levels, stable whenever the host is idle
    task automatic levels(input logic [3:0] vt, input logic [2:0] et, input logic [2:0] ct, input logic [2:0] pc);
        check("valid_threshold", {4'h0, preamble_valid_threshold}, {4'h0, vt});
        check("energy_threshold", {5'h00, preamble_search_energy_threshold}, {5'h00, et});
        check("carrier_sense", {5'h00, carrier_sense_threshold}, {5'h00, ct});
        check("counter_threshold", {5'h00, preamble_counter_threshold}, {5'h00, pc});
    endtask
    task automatic summarize();
        $display("%0d checks %0d errors", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always #2.5 clock = ~clock;
    initial begin
        repeat (400) @(posedge clock);
        num_errors++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'h0;
        rchk("ctrl_two_reset", 8'h3A, 8'h00);
        rchk("pre_thr_reset", 8'h3B, 8'hD8);
        rchk("cs_preamble_counter_threshold_reset", 8'h3C, 8'h9C);
        rchk("strength_reset", 8'h3E, 8'h01);
        levels(4'hD, 3'h4, 3'h4, 3'h7);
        check("per_packet_reset", {7'h00, strength_per_packet_enable}, 8'h00);
        rchk("unmapped", 8'h3F, 8'h00);
        host.xfer(1'h1, 8'h3F, 8'hFF, q);
        rchk("unmapped_write", 8'h3F, 8'h00);
        host.xfer(1'h1, 8'h3A, 8'hFF, q);
        rchk("ctrl_two", 8'h3A, 8'hFC);
        host.xfer(1'h1, 8'h3B, 8'h3E, q);
        host.xfer(1'h1, 8'h3C, 8'h10, q);
        rchk("pre_thr", 8'h3B, 8'h3E);
        rchk("cs_preamble_counter_threshold", 8'h3C, 8'h10);
        levels(4'h3, 3'h7, 3'h0, 3'h4);
        host.xfer(1'h1, 8'h3E, 8'h40, q);
        rchk("per_packet_on", 8'h3E, 8'h41);
        check("per_packet_pin", {7'h00, strength_per_packet_enable}, 8'h01);
        host.xfer(1'h1, 8'h3E, 8'hC0, q);
        rchk("busy", 8'h3E, 8'h40);
        repeat (2) @(posedge clock);
        rchk("done", 8'h3E, 8'h41);
        host.xfer(1'h1, 8'h3E, 8'h00, q);
        rchk("per_packet_off", 8'h3E, 8'h01);
        check("per_packet_pin_off", {7'h00, strength_per_packet_enable}, 8'h00);
        // second reset in mid-run brings the tuning values back
        @(posedge clock);
        rst <= 1'h1;
        repeat (2) @(posedge clock);
        rst <= 1'h0;
        rchk("pre_thr_again", 8'h3B, 8'hD8);
        rchk("ctrl_two_again", 8'h3A, 8'h00);
        levels(4'hD, 3'h4, 3'h4, 3'h7);
        summarize();
    end
endmodule
bind bbr_regs bbr_regs_monitor #(
    .MEAS_CYCLES (MEAS_CYCLES)
) mon (
    .clock                      (clock),
    .rst                        (rst),
    .addr                       (addr),
    .wdata                      (wdata),
    .wr                         (wr),
    .rd                         (rd),
    .rdata                      (rdata),
    .preamble_valid_threshold   (preamble_valid_threshold),
    .strength_per_packet_enable (strength_per_packet_enable),
    .strength_measure_start     (strength_measure_start),
    .strength_latch             (strength_latch)
);
